// ---- hw/sopc_pkg.sv ----
// Purpose: Shared constants and carriers of the system option control block
// Assumes: One bus clock; register indices are local to this block
// Notes:   Every offset, bit position, reset value and count is named here
`default_nettype none

package sopc_pkg;

  // ----------------------------------------------------------------
  // Register indices
  // ----------------------------------------------------------------
  localparam logic [2:0] SOPC_IDX_FORCE = 3'h0;
  localparam logic [2:0] SOPC_IDX_OPT1  = 3'h1;
  localparam logic [2:0] SOPC_IDX_OPT2  = 3'h2;
  localparam logic [2:0] SOPC_IDX_IDH   = 3'h3;
  localparam logic [2:0] SOPC_IDX_IDL   = 3'h4;
  localparam logic [2:0] SOPC_IDX_RSTS  = 3'h5;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int SOPC_FORCE_BIT   = 0;
  localparam int SOPC_OPT1_TO_LSB = 6;
  localparam int SOPC_OPT1_STOP   = 5;
  localparam int SOPC_OPT2_CLK    = 7;
  localparam int SOPC_OPT2_WIN    = 6;
  localparam int SOPC_OPT2_SPI1   = 2;
  localparam int SOPC_OPT2_SPI2   = 1;
  localparam int SOPC_OPT2_CMP    = 0;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [1:0] SOPC_RST_TIMEOUT = 2'h3;
  localparam logic       SOPC_RST_STOP    = 1'h0;
  localparam logic       SOPC_RST_CLK     = 1'h0;
  localparam logic       SOPC_RST_WIN     = 1'h0;
  localparam logic       SOPC_RST_SPI1    = 1'h0;
  localparam logic       SOPC_RST_SPI2    = 1'h0;
  localparam logic       SOPC_RST_CMP     = 1'h0;

  // Part number; value is arbitrary
  localparam logic [11:0] SOPC_PART_ID    = 12'h5a3;

  // ----------------------------------------------------------------
  // Watchdog service keys and overflow counts
  // ----------------------------------------------------------------
  localparam logic [7:0] SOPC_KEY_FIRST  = 8'h55;
  localparam logic [7:0] SOPC_KEY_SECOND = 8'haa;

  localparam int unsigned SOPC_LPO_OVF1 = 32;
  localparam int unsigned SOPC_LPO_OVF2 = 256;
  localparam int unsigned SOPC_LPO_OVF3 = 1024;
  localparam int unsigned SOPC_BUS_OVF1 = 8192;
  localparam int unsigned SOPC_BUS_OVF2 = 65536;
  localparam int unsigned SOPC_BUS_OVF3 = 262144;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [2:0] addr;
    logic [7:0] data;
  } sopc_req_s;

  typedef struct packed {
    logic [1:0] timeout;
    logic       stop_enable;
    logic       clk_sel;
    logic       window;
    logic       spi1_filt;
    logic       spi2_filt;
    logic       cmp_route;
  } sopc_opt_s;

  typedef struct packed {
    logic wdog;
    logic ilop;
  } sopc_cause_s;

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic level;
    logic tick;
  } sopc_sync_s;

endpackage : sopc_pkg

`default_nettype wire

// ---- hw/sopc_lpo_sync.sv ----
// Purpose: Bring the low-power oscillator into the bus clock domain
// Assumes: Oscillator far slower than the bus clock
// Notes:   Emits one bus-clock tick per rising oscillator edge
`timescale 1ns/10ps
`default_nettype none

module sopc_lpo_sync
(
  // Clock and reset
  input  wire logic mclk,
  input  wire logic rst,
  // Oscillator pin and tick
  input  wire logic lpo_pin,
  output logic      lpo_tick
);
  import sopc_pkg::*;

  sopc_sync_s st_ff;
  sopc_sync_s nxt_st;

  // ----------------------------------------------------------------
  // Three-stage sampler with agreement filter
  // ----------------------------------------------------------------
  // First stage feeds only the second, so metastability stays contained
  always_comb
  begin
    nxt_st       = st_ff;
    nxt_st.s1    = lpo_pin;
    nxt_st.s2    = st_ff.s1;
    nxt_st.s3    = st_ff.s2;
    nxt_st.tick  = 1'b0;
    if ((st_ff.s2 == st_ff.s3) && (st_ff.s3 != st_ff.level))
    begin
      nxt_st.level = st_ff.s3;
      nxt_st.tick  = st_ff.s3;    // Rising edge only
    end
  end

  // State register
  always_ff @(posedge mclk or posedge rst)
  begin
    // Start as if the pin were high, so an oscillator already high at
    // release is not taken for a fresh rising edge
    if (rst)
      st_ff <= '{s1: 1'b1, s2: 1'b1, s3: 1'b1, level: 1'b1, tick: 1'b0};
    else
      st_ff <= nxt_st;
  end

  assign lpo_tick = st_ff.tick;

endmodule : sopc_lpo_sync

`default_nettype wire

// ---- hw/sopc_top.sv ----
// Purpose: System option registers, watchdog and debug forced reset
// Assumes: Reset controller turns rst_req into rst and latches causes
// Notes:   Debug port writes win over user port writes in one cycle
`timescale 1ns/10ps
`default_nettype none

module sopc_top
#(
  parameter int unsigned BUS_OVF1 = sopc_pkg::SOPC_BUS_OVF1,
  parameter int unsigned BUS_OVF2 = sopc_pkg::SOPC_BUS_OVF2,
  parameter int unsigned BUS_OVF3 = sopc_pkg::SOPC_BUS_OVF3
)
(
  // Clock and reset
  input  wire logic                  mclk,
  input  wire logic                  rst,
  // User program register port
  input  wire sopc_pkg::sopc_req_s   cpu_req,
  output logic [7:0]                 cpu_rdata,
  // Background debug register port
  input  wire sopc_pkg::sopc_req_s   bdc_req,
  output logic [7:0]                 bdc_rdata,
  // Low-power oscillator pin
  input  wire logic                  lpo_clk,
  // Core stop request
  input  wire logic                  stop_exec,
  output logic                       stop_grant,
  // Comparator routing
  input  wire logic                  analog_comparator_out,
  output logic                       tpm_ch0_cmp,
  // Option fields to the chip
  output var sopc_pkg::sopc_opt_s    opt_out,
  // Reset request to the reset controller
  output logic                       rst_req,
  output var sopc_pkg::sopc_cause_s  rst_cause
);
  import sopc_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0]  timeout;
    logic        stop_en;
    logic        opt1_done;
    logic        clk_sel;
    logic        window;
    logic        opt2_done;
    logic        spi1_filt;
    logic        spi2_filt;
    logic        cmp_route;
    logic [17:0] wdog_cnt;
    logic        armed;
    logic        rst_req;
    sopc_cause_s cause;
    logic [7:0]  cpu_rdata;
    logic [7:0]  bdc_rdata;
    logic        stop_grant;
    logic        tpm_ch0;
  } sopc_state_s;

  sopc_state_s st_ff;
  sopc_state_s nxt_st;
  logic        lpo_tick;
  sopc_req_s   wr_req;
  logic        wr_from_bdc;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Overflow count of the selected timeout
  function automatic logic [18:0] ovf_of(input logic sel,
                                         input logic [1:0] to);
    logic [18:0] n;
    n = 19'h0;
    if (sel)
    begin
      if (to == 2'h1)
        n = 19'(BUS_OVF1);
      else if (to == 2'h2)
        n = 19'(BUS_OVF2);
      else if (to == 2'h3)
        n = 19'(BUS_OVF3);
    end
    else
    begin
      if (to == 2'h1)
        n = 19'(SOPC_LPO_OVF1);
      else if (to == 2'h2)
        n = 19'(SOPC_LPO_OVF2);
      else if (to == 2'h3)
        n = 19'(SOPC_LPO_OVF3);
    end
    return n;
  endfunction : ovf_of

  // Window opens after three quarters of the period
  function automatic logic [18:0] win_of(input logic [18:0] ovf);
    return ovf - (ovf >> 2);
  endfunction : win_of

  // Read value of one register index
  function automatic logic [7:0] read_of(input logic [2:0] a,
                                         input sopc_state_s s);
    logic [7:0] d;
    d = 8'h00;
    if (a == SOPC_IDX_OPT1)
    begin
      d[SOPC_OPT1_TO_LSB +: 2] = s.timeout;
      d[SOPC_OPT1_STOP]        = s.stop_en;
    end
    else if (a == SOPC_IDX_OPT2)
    begin
      d[SOPC_OPT2_CLK]  = s.clk_sel;
      d[SOPC_OPT2_WIN]  = s.window;
      d[SOPC_OPT2_SPI1] = s.spi1_filt;
      d[SOPC_OPT2_SPI2] = s.spi2_filt;
      d[SOPC_OPT2_CMP]  = s.cmp_route;
    end
    else if (a == SOPC_IDX_IDH)
      d = {4'h0, SOPC_PART_ID[11:8]};
    else if (a == SOPC_IDX_IDL)
      d = SOPC_PART_ID[7:0];
    // Force register and unmapped indices read zero
    return d;
  endfunction : read_of

  // ----------------------------------------------------------------
  // Oscillator tick
  // ----------------------------------------------------------------
  sopc_lpo_sync u_lpo_sync
  (
    .mclk     (mclk),
    .rst      (rst),
    .lpo_pin  (lpo_clk),
    .lpo_tick (lpo_tick)
  );

  // ----------------------------------------------------------------
  // Write source selection
  // ----------------------------------------------------------------
  // Debug host wins; the core is halted while it issues commands
  always_comb
  begin
    wr_from_bdc = bdc_req.wr;
    if (bdc_req.wr)
      wr_req = bdc_req;
    else
      wr_req = cpu_req;
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    logic [18:0] ovf;
    logic        wd_on;
    logic        tick;
    ovf            = ovf_of(st_ff.clk_sel, st_ff.timeout);
    wd_on          = (st_ff.timeout != 2'h0);
    tick           = st_ff.clk_sel | lpo_tick;
    nxt_st         = st_ff;
    nxt_st.rst_req = 1'b0;
    nxt_st.cause   = '0;
    nxt_st.stop_grant = 1'b0;

    // Watchdog count and overflow
    if (wd_on && tick)
    begin
      if ({1'b0, st_ff.wdog_cnt} == ovf - 19'h1)
      begin
        nxt_st.wdog_cnt   = 18'h0;
        nxt_st.rst_req    = 1'b1;
        nxt_st.cause.wdog = 1'b1;
      end
      else
        nxt_st.wdog_cnt = st_ff.wdog_cnt + 18'h1;
    end

    // Option register one, first write only
    if (wr_req.wr && wr_req.addr == SOPC_IDX_OPT1 && !st_ff.opt1_done)
    begin
      nxt_st.timeout   = wr_req.data[SOPC_OPT1_TO_LSB +: 2];
      nxt_st.stop_en   = wr_req.data[SOPC_OPT1_STOP];
      nxt_st.opt1_done = 1'b1;
      nxt_st.wdog_cnt  = 18'h0;    // New period starts cleanly
      nxt_st.armed     = 1'b0;
    end

    // Option register two; only clock and window are write once
    if (wr_req.wr && wr_req.addr == SOPC_IDX_OPT2)
    begin
      if (!st_ff.opt2_done)
      begin
        nxt_st.clk_sel   = wr_req.data[SOPC_OPT2_CLK];
        nxt_st.window    = wr_req.data[SOPC_OPT2_WIN];
        nxt_st.opt2_done = 1'b1;
        nxt_st.wdog_cnt  = 18'h0;
        nxt_st.armed     = 1'b0;
      end
      nxt_st.spi1_filt = wr_req.data[SOPC_OPT2_SPI1];
      nxt_st.spi2_filt = wr_req.data[SOPC_OPT2_SPI2];
      nxt_st.cmp_route = wr_req.data[SOPC_OPT2_CMP];
    end

    // Watchdog service through the reset status address
    if (wr_req.wr && wr_req.addr == SOPC_IDX_RSTS && wd_on)
    begin
      if (!st_ff.window)
      begin
        nxt_st.wdog_cnt = 18'h0;
        nxt_st.armed    = 1'b0;
      end
      else if ({1'b0, st_ff.wdog_cnt} < win_of(ovf))
      begin
        nxt_st.rst_req    = 1'b1;
        nxt_st.cause.wdog = 1'b1;
      end
      else if (wr_req.data == SOPC_KEY_FIRST)
        nxt_st.armed = 1'b1;
      else if (wr_req.data == SOPC_KEY_SECOND && st_ff.armed)
      begin
        nxt_st.wdog_cnt = 18'h0;
        nxt_st.armed    = 1'b0;
      end
      else
        nxt_st.armed = 1'b0;
    end

    // STOP instruction: grant or illegal opcode reset
    if (stop_exec)
    begin
      if (st_ff.stop_en)
        nxt_st.stop_grant = 1'b1;
      else
      begin
        nxt_st.rst_req    = 1'b1;
        nxt_st.cause.ilop = 1'b1;
      end
    end

    // Debug forced reset; user writes never reach it
    if (wr_req.wr && wr_from_bdc && wr_req.addr == SOPC_IDX_FORCE &&
        wr_req.data[SOPC_FORCE_BIT])
    begin
      nxt_st.rst_req = 1'b1;
      nxt_st.cause   = '0;
    end

    // Register reads, one cycle latency
    if (cpu_req.rd)
      nxt_st.cpu_rdata = read_of(cpu_req.addr, st_ff);
    if (bdc_req.rd)
      nxt_st.bdc_rdata = read_of(bdc_req.addr, st_ff);

    // Comparator to capture input, gated by the route bit
    nxt_st.tpm_ch0 = st_ff.cmp_route & analog_comparator_out;
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  // Any reset rearms write once and restarts the watchdog
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      st_ff           <= '0;
      st_ff.timeout   <= SOPC_RST_TIMEOUT;
      st_ff.stop_en   <= SOPC_RST_STOP;
      st_ff.clk_sel   <= SOPC_RST_CLK;
      st_ff.window    <= SOPC_RST_WIN;
      st_ff.spi1_filt <= SOPC_RST_SPI1;
      st_ff.spi2_filt <= SOPC_RST_SPI2;
      st_ff.cmp_route <= SOPC_RST_CMP;
    end
    else
      st_ff <= nxt_st;
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign cpu_rdata   = st_ff.cpu_rdata;
  assign bdc_rdata   = st_ff.bdc_rdata;
  assign stop_grant  = st_ff.stop_grant;
  assign tpm_ch0_cmp = st_ff.tpm_ch0;
  assign rst_req     = st_ff.rst_req;
  assign rst_cause   = st_ff.cause;

  // Option fields straight from their flip-flops
  assign opt_out.timeout     = st_ff.timeout;
  assign opt_out.stop_enable = st_ff.stop_en;
  assign opt_out.clk_sel     = st_ff.clk_sel;
  assign opt_out.window      = st_ff.window;
  assign opt_out.spi1_filt   = st_ff.spi1_filt;
  assign opt_out.spi2_filt   = st_ff.spi2_filt;
  assign opt_out.cmp_route   = st_ff.cmp_route;

endmodule : sopc_top

`default_nettype wire

// ---- verif/sopc_props.sv ----
// Purpose: Port assertions for the system option control block
// Assumes: Bound to sopc_top; one clock, reset active high
// Notes:   A debug forced reset is the only request with cause 00
`timescale 1ns/10ps
`default_nettype none

module sopc_props
#(
  parameter int unsigned BUS_OVF1 = 64,
  parameter int unsigned BUS_OVF2 = 128,
  parameter int unsigned BUS_OVF3 = 256
)
(
  // Clock and reset
  input  wire logic                  mclk,
  input  wire logic                  rst,
  // Register ports
  input  wire sopc_pkg::sopc_req_s   cpu_req,
  input  wire logic [7:0]            cpu_rdata,
  input  wire sopc_pkg::sopc_req_s   bdc_req,
  input  wire logic [7:0]            bdc_rdata,
  // Stop, comparator, options, reset request
  input  wire logic                  stop_exec,
  input  wire logic                  stop_grant,
  input  wire logic                  analog_comparator_out,
  input  wire logic                  tpm_ch0_cmp,
  input  wire sopc_pkg::sopc_opt_s   opt_out,
  input  wire logic                  rst_req,
  input  wire sopc_pkg::sopc_cause_s rst_cause
);
  import sopc_pkg::*;

  // ----------------------------------------------------------------
  // Write-once history, seen from the ports only
  // ----------------------------------------------------------------
  logic w1;
  logic w2;
  logic lock1_ff;
  logic lock2_ff;
  logic dbg_force;

  // Any port may make the first write, so both are watched
  assign w1 = (cpu_req.wr && cpu_req.addr == SOPC_IDX_OPT1)
           || (bdc_req.wr && bdc_req.addr == SOPC_IDX_OPT1);
  assign w2 = (cpu_req.wr && cpu_req.addr == SOPC_IDX_OPT2)
           || (bdc_req.wr && bdc_req.addr == SOPC_IDX_OPT2);
  assign dbg_force = bdc_req.wr && bdc_req.addr == SOPC_IDX_FORCE;

  // Locks close on the first write, reopen on reset
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      lock1_ff <= 1'b0;
      lock2_ff <= 1'b0;
    end
    else
    begin
      lock1_ff <= lock1_ff | w1;
      lock2_ff <= lock2_ff | w2;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  property p_user_force;
    cpu_req.wr && cpu_req.addr == SOPC_IDX_FORCE && !dbg_force
      |=> !(rst_req && rst_cause == '0);
  endproperty
  a_user_force: assert property (p_user_force)
    else $error("user write forced a reset");

  property p_force_zero;
    bdc_req.rd && bdc_req.addr == SOPC_IDX_FORCE |=> bdc_rdata == 8'h00;
  endproperty
  a_force_zero: assert property (p_force_zero)
    else $error("force register read not zero");

  property p_dbg_reset;
    dbg_force && bdc_req.data[SOPC_FORCE_BIT]
      |=> rst_req && rst_cause == '0 ##1 !rst_req;
  endproperty
  a_dbg_reset: assert property (p_dbg_reset)
    else $error("debug force gave no clean reset pulse");

  property p_opt1_gap;
    cpu_req.rd && cpu_req.addr == SOPC_IDX_OPT1 |=> cpu_rdata[3:2] == 2'b00;
  endproperty
  a_opt1_gap: assert property (p_opt1_gap)
    else $error("options one bits 3:2 not zero");

  property p_opt1_lock;
    lock1_ff && w1 |=> $stable(opt_out.timeout) && $stable(opt_out.stop_enable);
  endproperty
  a_opt1_lock: assert property (p_opt1_lock)
    else $error("options one changed after first write");

  property p_wd_off;
    opt_out.timeout == 2'h0 |=> !rst_cause.wdog;
  endproperty
  a_wd_off: assert property (p_wd_off)
    else $error("watchdog reset while disabled");

  property p_stop_bad;
    stop_exec && !opt_out.stop_enable && !dbg_force
      |=> rst_req && rst_cause.ilop && !stop_grant;
  endproperty
  a_stop_bad: assert property (p_stop_bad)
    else $error("disabled stop did not reset");

  property p_stop_ok;
    stop_exec && opt_out.stop_enable |=> stop_grant;
  endproperty
  a_stop_ok: assert property (p_stop_ok)
    else $error("enabled stop not granted");

  property p_opt2_lock;
    lock2_ff && w2 |=> $stable(opt_out.clk_sel) && $stable(opt_out.window);
  endproperty
  a_opt2_lock: assert property (p_opt2_lock)
    else $error("clock or window bit changed after first write");

  property p_cmp_route;
    analog_comparator_out && opt_out.cmp_route |=> tpm_ch0_cmp;
  endproperty
  a_cmp_route: assert property (p_cmp_route)
    else $error("comparator not routed to timer");

  property p_id_low;
    cpu_req.rd && cpu_req.addr == SOPC_IDX_IDL |=> cpu_rdata == SOPC_PART_ID[7:0];
  endproperty
  a_id_low: assert property (p_id_low)
    else $error("part number low byte wrong");

  property p_id_high;
    cpu_req.rd && cpu_req.addr == SOPC_IDX_IDH
      |=> cpu_rdata[3:0] == SOPC_PART_ID[11:8];
  endproperty
  a_id_high: assert property (p_id_high)
    else $error("part number high nibble wrong");

endmodule : sopc_props

bind sopc_top sopc_props #(.BUS_OVF1(BUS_OVF1), .BUS_OVF2(BUS_OVF2),
  .BUS_OVF3(BUS_OVF3)) u_props (.mclk(mclk), .rst(rst), .cpu_req(cpu_req),
  .cpu_rdata(cpu_rdata), .bdc_req(bdc_req), .bdc_rdata(bdc_rdata),
  .stop_exec(stop_exec), .stop_grant(stop_grant), .analog_comparator_out(analog_comparator_out),
  .tpm_ch0_cmp(tpm_ch0_cmp), .opt_out(opt_out), .rst_req(rst_req),
  .rst_cause(rst_cause));

`default_nettype wire

// ---- verif/sopc_dbg_host.sv ----
// Purpose: External debug host issuing background register commands
// Assumes: One command at a time, taken on the edge after it is raised
// Notes:   Idle address and data lines show the inverse of the last command; wr and rd drop to zero
`timescale 1ns/10ps
`default_nettype none

module sopc_dbg_host
(
  // Clock
  input  wire logic                mclk,
  // Background command and answer
  output var  sopc_pkg::sopc_req_s bdc_req,
  input  wire logic [7:0]          bdc_rdata
);
  import sopc_pkg::*;

  initial bdc_req = '0;

  // Hold the command up to the taking edge, then scramble idle lines
  task automatic send(input logic w, input logic [2:0] a, input logic [7:0] d);
    @(posedge mclk);
    bdc_req <= '{wr: w, rd: !w, addr: a, data: d};
    @(posedge mclk);
    bdc_req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, data: ~d};
  endtask : send

  // Read answer is registered, so look after the taking edge lands
  task automatic rd(input logic [2:0] a, output logic [7:0] d);
    send(1'b0, a, 8'h00);
    @(negedge mclk);
    d = bdc_rdata;
  endtask : rd

endmodule : sopc_dbg_host

`default_nettype wire

// ---- verif/sopc_top_test.sv ----
// Purpose: Directed register and watchdog sequences for sopc_top
// Assumes: Bench plays the reset controller after every rst_req
// Notes:   Bus overflow counts shortened; oscillator runs at 5 MHz
`timescale 1ns/10ps
`default_nettype none

module sopc_top_test;
  import sopc_pkg::*;

  localparam int unsigned OVF1 = 64;
  localparam int unsigned OVF2 = 128;
  localparam int unsigned OVF3 = 256;
  localparam int          LPO_P = 20; // Oscillator period in mclk cycles

  logic        mclk, rst, lpo_clk, stop_exec, analog_comparator_out;
  logic        stop_grant, tpm_ch0_cmp, rst_req;
  logic [7:0]  cpu_rdata, bdc_rdata, rd_v;
  sopc_req_s   cpu_req, bdc_req;
  sopc_opt_s   opt_out;
  sopc_cause_s rst_cause;
  int          n_fail, n_tests, n, lo, hi;
  int unsigned ovf_t [6] = '{SOPC_LPO_OVF1, SOPC_LPO_OVF2, SOPC_LPO_OVF3,
                             OVF1, OVF2, OVF3};

  sopc_top #(.BUS_OVF1(OVF1), .BUS_OVF2(OVF2), .BUS_OVF3(OVF3)) DUT (
    .mclk(mclk), .rst(rst), .cpu_req(cpu_req), .cpu_rdata(cpu_rdata),
    .bdc_req(bdc_req), .bdc_rdata(bdc_rdata), .lpo_clk(lpo_clk),
    .stop_exec(stop_exec), .stop_grant(stop_grant), .analog_comparator_out(analog_comparator_out),
    .tpm_ch0_cmp(tpm_ch0_cmp), .opt_out(opt_out), .rst_req(rst_req),
    .rst_cause(rst_cause));

  sopc_dbg_host host (.mclk(mclk), .bdc_req(bdc_req), .bdc_rdata(bdc_rdata));

  // ----------------------------------------------------------------
  // Clocks; oscillator phase kept apart from mclk edges
  // ----------------------------------------------------------------
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  initial
  begin
    lpo_clk = 1'b0;
    #3;
    forever #(LPO_P * 5) lpo_clk = ~lpo_clk;
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic wrap_up;
    $display("mismatches %0d of %0d compares", n_fail, n_tests);
    if (n_fail == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : wrap_up

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic send(input logic w, input logic [2:0] a, input logic [7:0] d);
    @(posedge mclk);
    cpu_req <= '{wr: w, rd: !w, addr: a, data: d};
    @(posedge mclk);
    cpu_req <= '{wr: 1'b0, rd: 1'b0, addr: ~a, data: ~d};
  endtask : send

  task automatic cw(input logic [2:0] a, input logic [7:0] d);
    send(1'b1, a, d);
  endtask : cw

  task automatic cr(input logic [2:0] a, input logic [7:0] exp);
    send(1'b0, a, 8'h00);
    @(negedge mclk);
    check(cpu_rdata, exp);
  endtask : cr

  // No reset request may appear for k cycles
  task automatic quiet(input int k);
    repeat (k)
    begin
      @(negedge mclk);
      check({7'h00, rst_req}, 8'h00);
    end
  endtask : quiet

  // Cycles until the reset request; a hang ends the run
  task automatic wait_rst(input int bound, output int cnt);
    cnt = 0;
    while (rst_req !== 1'b1 && cnt <= bound)
    begin
      @(negedge mclk);
      cnt++;
    end
    if (cnt > bound)
    begin
      n_fail++;
      wrap_up();
    end
  endtask : wait_rst

  task automatic do_reset;
    @(posedge mclk);
    rst <= 1'b1;
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
  endtask : do_reset

  task automatic stop_pulse;
    @(posedge mclk);
    stop_exec <= 1'b1;
    @(posedge mclk);
    stop_exec <= 1'b0;
    @(negedge mclk);
  endtask : stop_pulse

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    rst = 1'b1;
    cpu_req = '0;
    stop_exec = 1'b0;
    analog_comparator_out = 1'b0;
    n_fail = 0;
    n_tests = 0;
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    // Reset view and read-only places
    cr(SOPC_IDX_FORCE, 8'h00);
    cr(SOPC_IDX_OPT1, 8'hc0);
    cr(SOPC_IDX_OPT2, 8'h00);
    cr(SOPC_IDX_IDL, SOPC_PART_ID[7:0]);
    host.rd(SOPC_IDX_FORCE, rd_v);
    check(rd_v, 8'h00);
    cw(SOPC_IDX_FORCE, 8'hff);
    quiet(3);
    cw(SOPC_IDX_IDH, 8'hff);
    cw(SOPC_IDX_IDL, 8'h00);
    cr(SOPC_IDX_IDH, {4'h0, SOPC_PART_ID[11:8]});
    cr(SOPC_IDX_IDL, SOPC_PART_ID[7:0]);
    stop_pulse();
    check({4'h0, rst_req, stop_grant, rst_cause}, 8'h09);
    do_reset();
    // Option fields, write-once locks, routing, early window write
    cw(SOPC_IDX_OPT1, 8'h6c);
    cr(SOPC_IDX_OPT1, 8'h60);
    cw(SOPC_IDX_OPT1, 8'h80);
    cr(SOPC_IDX_OPT1, 8'h60);
    stop_pulse();
    check({4'h0, rst_req, stop_grant, rst_cause}, 8'h04);
    cw(SOPC_IDX_OPT2, 8'hff);
    cr(SOPC_IDX_OPT2, 8'hc7);
    check(opt_out, 8'h7f);
    @(posedge mclk);
    analog_comparator_out <= 1'b1;
    repeat (2) @(negedge mclk);
    check({7'h00, tpm_ch0_cmp}, 8'h01);
    cw(SOPC_IDX_OPT2, 8'h00);
    cr(SOPC_IDX_OPT2, 8'hc0);
    check({7'h00, tpm_ch0_cmp}, 8'h00);
    cw(SOPC_IDX_RSTS, SOPC_KEY_FIRST);
    wait_rst(3, n);
    check({6'h00, rst_cause}, 8'h02);
    do_reset();
    // Window service inside the last quarter keeps the count alive
    cw(SOPC_IDX_OPT1, 8'h40);
    cw(SOPC_IDX_OPT2, 8'hc0);
    repeat (52) @(posedge mclk);
    cw(SOPC_IDX_RSTS, SOPC_KEY_FIRST);
    cw(SOPC_IDX_RSTS, SOPC_KEY_SECOND);
    quiet(40);
    wait_rst(40, n);
    check({6'h00, rst_cause}, 8'h02);
    do_reset();
    // Normal mode: any status write services; then debug force
    cw(SOPC_IDX_OPT1, 8'h40);
    cw(SOPC_IDX_OPT2, 8'h80);
    repeat (4)
    begin
      quiet(50);
      cw(SOPC_IDX_RSTS, 8'h3c);
    end
    host.send(1'b1, SOPC_IDX_FORCE, 8'h01);
    @(negedge mclk);
    check({5'h00, rst_req, rst_cause}, 8'h04);
    do_reset();
    // Timeout code zero: no overflow on the fast clock
    cw(SOPC_IDX_OPT1, 8'h00);
    cw(SOPC_IDX_OPT2, 8'h80);
    quiet(300);
    do_reset();
    // Timeout codes 1 to 3 on both clocks
    for (int i = 0; i < 6; i++)
    begin
      lo = (i < 3) ? (ovf_t[i] - 1) * LPO_P : ovf_t[i] - 3;
      hi = (i < 3) ? ovf_t[i] * LPO_P + 10 : ovf_t[i] + 3;
      cw(SOPC_IDX_OPT1, {2'(i % 3 + 1), 6'h00});
      cw(SOPC_IDX_OPT2, {i >= 3, 7'h00});
      wait_rst(hi + 5, n);
      check({7'h00, n >= lo && n <= hi}, 8'h01);
      check({6'h00, rst_cause}, 8'h02);
      do_reset();
    end
    wrap_up();
  end

endmodule : sopc_top_test

`default_nettype wire
